// ==== edhp_buf.sv ====
// two-entry valid/ready buffer
`timescale 1ns/1ps
module edhp_buf
    import edhp_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable
    input wire edhp_word_t in_word, // fill data
    input wire logic in_valid, // fill valid
    output logic in_ready, // room for a word
    output edhp_word_t out_word, // drain data
    output logic out_valid, // word waiting
    input wire logic out_ready // drain accepts
);
    edhp_word_t mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    wire push = ce && in_valid && in_ready;
    wire pop = ce && out_valid && out_ready;
    // honest full and empty
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_word = mem_q[rp_q];
    // pointers and count
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wp_q] <= in_word;
                wp_q <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // edhp_buf

// ==== edhp_params.svh ====
// constants of the external dma handshake port
`ifndef EDHP_PARAMS_SVH
`define EDHP_PARAMS_SVH
`define EDHP_ADDR_W 24
`define EDHP_DATA_W 32
`define EDHP_SEL_W 4
`define EDHP_WAIT_W 4
// register offsets on the plain port
`define EDHP_REG_CTRL 4'h0
`define EDHP_REG_ADDR 4'h1
`define EDHP_REG_STAT 4'h2
`define EDHP_REG_DATA 4'h3
`define EDHP_REG_WDATA 4'h4
`define EDHP_REG_COUNT 4'h5
// control field positions
`define EDHP_CTRL_EN 0
`define EDHP_CTRL_MODE_LO 1
`define EDHP_CTRL_MODE_HI 2
`define EDHP_CTRL_DIR 3
`define EDHP_CTRL_SYNC 4
`define EDHP_CTRL_IDLE 5
`define EDHP_CTRL_WAIT_LO 8
`define EDHP_CTRL_WAIT_HI 11
`define EDHP_CTRL_SEL_LO 12
`define EDHP_CTRL_SEL_HI 15
`define EDHP_CTRL_RST 32'h0000_0000
`define EDHP_ONE_WAIT 4'h1
`define EDHP_ONE_ADDR 24'h00_0001
`define EDHP_ONE_CNT 16'h0001
`endif

// ==== edhp_peer.sv ====
// model of the requesting peripheral
`timescale 1ns/1ps
module edhp_peer
(
    input wire logic core_clk, // clock
    input wire logic grant_n, // grant strobe
    input wire logic rd_n, // read strobe
    input wire logic wr_n, // write strobe
    output logic request_n, // request pin
    output logic ack, // bus ready
    output logic [31:0] data // data to the port
);
    logic [31:0] word_q = 32'hc0de_0000;
    wire served = !grant_n || !rd_n || !wr_n;
    initial request_n = 1'b1;
    initial data = 32'h0;
    assign ack = 1'b1;
    // data valid while asked or served, inverted otherwise
    always @(posedge core_clk) data <= (served || !request_n) ? word_q : ~word_q;
    // n transfers, request held hold cycles after service
    task automatic run(input int n, input int hold);
        int k;
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk);
            request_n <= 1'b0;
            k = 0;
            while (!served && k < 300)
            begin
                @(posedge core_clk);
                k++;
            end
            repeat (hold) @(posedge core_clk);
            request_n <= 1'b1;
            k = 0;
            while (served && k < 50)
            begin
                @(posedge core_clk);
                k++;
            end
            word_q <= word_q + 32'h1;
        end
    endtask
endmodule // edhp_peer

// ==== edhp_pkg.sv ====
// types of the external dma handshake port
package edhp_pkg;
    // handshake mode
    typedef enum logic [1:0]
    {
        EDHP_MODE_HS = 2'b00,
        EDHP_MODE_EXT = 2'b01,
        EDHP_MODE_PACED = 2'b10
    } edhp_mode_t;
    // external bus pins driven by the port
    typedef struct packed
    {
        logic [23:0] addr;
        logic rd_n;
        logic wr_n;
        logic [3:0] sel_n;
        logic grant_n;
        logic data_oe;
    } edhp_bus_t;
    // one word through the buffer
    typedef struct packed
    {
        logic [31:0] data;
    } edhp_word_t;
endpackage

// ==== edhp_port.sv ====
// dma handshake port: request, grant and bus strobes
// ==========================================
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "edhp_params.svh"
module edhp_port
    import edhp_pkg::*;
(
    input wire logic core_clk, // 100 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [3:0] reg_addr, // register index
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, next cycle
    input wire logic channel_dma_request_n, // request pin
    input wire logic ack_in, // acknowledge pin
    input wire logic [31:0] data_in, // external data pins in
    output logic [23:0] ext_addr, // external address
    output logic rd_n, // read strobe pin
    output logic wr_n, // write strobe pin
    output logic [3:0] memory_select_n, // memory selects
    output logic channel_dma_grant_n, // grant strobe pin
    output logic [31:0] data_out, // external data pins out
    output logic data_oe // data pins driven
);
    // ==========================================
    // state
    typedef enum logic [2:0]
    {
        EDHP_S_IDLE = 3'b000,
        EDHP_S_GAP = 3'b001,
        EDHP_S_STROBE = 3'b010,
        EDHP_S_WAIT = 3'b011,
        EDHP_S_HOLD = 3'b100,
        EDHP_S_END = 3'b101
    } edhp_state_t;
    edhp_state_t st_q;
    edhp_state_t st_d;
    logic [31:0] ctrl_q;
    logic [23:0] addr_q;
    logic [15:0] cnt_q;
    logic [3:0] wcnt_q;
    logic idle_q;
    edhp_bus_t bus_q;
    edhp_bus_t bus_d;
    logic [31:0] rdata_q;
    logic [31:0] dout_q;
    logic [31:0] wdata_q;
    logic req_n_s;
    logic ack_s;
    logic [31:0] rd_word;
    // ==========================================
    // pin synchronisers
    edhp_sync u_sync_req
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .rst_val(1'b1),
        .din(channel_dma_request_n),
        .dout(req_n_s)
    );
    edhp_sync u_sync_ack
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .rst_val(1'b1),
        .din(~ack_in),
        .dout(ack_s)
    );
    // ==========================================
    // control decode
    wire en = ctrl_q[`EDHP_CTRL_EN];
    wire [1:0] mode_raw = ctrl_q[`EDHP_CTRL_MODE_HI:`EDHP_CTRL_MODE_LO];
    wire is_write = ctrl_q[`EDHP_CTRL_DIR];
    wire sync_mode = ctrl_q[`EDHP_CTRL_SYNC];
    wire idle_cfg = ctrl_q[`EDHP_CTRL_IDLE];
    wire [3:0] wait_cfg = ctrl_q[`EDHP_CTRL_WAIT_HI:`EDHP_CTRL_WAIT_LO];
    wire [3:0] sel_cfg = ctrl_q[`EDHP_CTRL_SEL_HI:`EDHP_CTRL_SEL_LO];
    wire mode_hs = (mode_raw == EDHP_MODE_HS);
    wire mode_paced = (mode_raw == EDHP_MODE_PACED);
    wire uses_bus = !mode_hs;
    wire ack_ok = mode_hs || !ack_s;
    wire req_on = !req_n_s; // sampled request, seen two edges after the pin through the two-flop synchroniser
    wire busy = (st_q != EDHP_S_IDLE);
    // read words drained from the bus into the buffer
    edhp_word_t fill_word;
    logic fill_valid;
    logic fill_ready;
    edhp_word_t drain_word;
    logic drain_valid;
    wire drain_ready = reg_rd && (reg_addr == `EDHP_REG_DATA) && ce;
    assign fill_word.data = data_in;
    assign fill_valid = (st_q == EDHP_S_END) && !is_write;
    edhp_buf u_buf
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .in_word(fill_word),
        .in_valid(fill_valid),
        .in_ready(fill_ready),
        .out_word(drain_word),
        .out_valid(drain_valid),
        .out_ready(drain_ready)
    );
    // a read waits while the buffer is full
    wire can_start = en && (cnt_q != 16'h0) && (is_write || fill_ready);
    // ==========================================
    // next state
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            EDHP_S_IDLE:
                if (can_start && req_on) // only a low request starts it
                    st_d = EDHP_S_STROBE;
            EDHP_S_STROBE:
                if (wait_cfg != 4'h0)
                    st_d = EDHP_S_WAIT; // stretch overlap by wait states
                else if (ack_ok)
                    st_d = EDHP_S_HOLD;
            EDHP_S_WAIT:
                if (wcnt_q == `EDHP_ONE_WAIT && ack_ok)
                    st_d = EDHP_S_HOLD;
            EDHP_S_HOLD:
                if (!req_on)
                    st_d = EDHP_S_END; // request low holds the access open
            EDHP_S_END:
                if (idle_cfg)
                    st_d = EDHP_S_GAP; // one more period of grant high
                else
                    st_d = EDHP_S_IDLE;
            EDHP_S_GAP:
                st_d = EDHP_S_IDLE;
            default:
                st_d = EDHP_S_IDLE;
        endcase
    end
    // ==========================================
    // pin values per state
    wire strobing = (st_q == EDHP_S_STROBE) || (st_q == EDHP_S_WAIT) || (st_q == EDHP_S_HOLD);
    wire next_strobe = (st_d == EDHP_S_STROBE) || (st_d == EDHP_S_WAIT) || (st_d == EDHP_S_HOLD);
    // outside sync mode the grant outlives the strobe by one period
    wire grant_tail = (st_d == EDHP_S_END) && uses_bus && !sync_mode;
    always_comb
    begin
        bus_d.addr = next_strobe && uses_bus ? addr_q : 24'h00_0000; // address in bus modes
        bus_d.sel_n = next_strobe && uses_bus ? ~sel_cfg : 4'hf;
        // strobe ends with grant in sync mode, a period early otherwise
        bus_d.rd_n = !(next_strobe && uses_bus && !is_write);
        bus_d.wr_n = !(next_strobe && uses_bus && is_write);
        bus_d.grant_n = !((next_strobe || grant_tail) && !mode_paced); // grant only outside paced mode
        bus_d.data_oe = next_strobe && is_write;
    end
    // ==========================================
    // state and bus registers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= EDHP_S_IDLE;
            bus_q <= {24'h00_0000, 1'b1, 1'b1, 4'hf, 1'b1, 1'b0}; // grant high from reset
            wcnt_q <= 4'h0;
        end
        else if (ce)
        begin
            st_q <= st_d;
            bus_q <= bus_d;
            if (st_d == EDHP_S_STROBE)
                wcnt_q <= wait_cfg; // load programmed wait states
            else if (st_q == EDHP_S_WAIT && wcnt_q != 4'h0)
                wcnt_q <= wcnt_q - `EDHP_ONE_WAIT;
        end
    end
    // ==========================================
    // software registers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= `EDHP_CTRL_RST;
            addr_q <= 24'h00_0000;
            cnt_q <= 16'h0000;
            wdata_q <= 32'h0000_0000;
            dout_q <= 32'h0000_0000;
            idle_q <= 1'b0;
        end
        else if (ce)
        begin
            if (reg_wr && reg_addr == `EDHP_REG_CTRL)
                ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == `EDHP_REG_WDATA)
                wdata_q <= reg_wdata;
            if (st_q == EDHP_S_END)
            begin
                addr_q <= addr_q + `EDHP_ONE_ADDR;
                cnt_q <= cnt_q - `EDHP_ONE_CNT;
            end
            else
            begin
                if (reg_wr && reg_addr == `EDHP_REG_ADDR)
                    addr_q <= reg_wdata[23:0];
                if (reg_wr && reg_addr == `EDHP_REG_COUNT)
                    cnt_q <= reg_wdata[15:0];
            end
            if (st_d == EDHP_S_STROBE)
                dout_q <= wdata_q;
            idle_q <= (st_q == EDHP_S_GAP);
        end
    end
    // ==========================================
    // read data mux
    always_comb
    begin
        case (reg_addr)
            `EDHP_REG_CTRL: rd_word = ctrl_q;
            `EDHP_REG_ADDR: rd_word = {8'h00, addr_q};
            `EDHP_REG_STAT: rd_word = {24'h00_0000, idle_q, drain_valid, fill_ready, !req_n_s, 1'b0, st_q};
            `EDHP_REG_DATA: rd_word = drain_valid ? drain_word.data : 32'h0000_0000;
            `EDHP_REG_WDATA: rd_word = wdata_q;
            `EDHP_REG_COUNT: rd_word = {16'h0000, cnt_q};
            default: rd_word = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= 32'h0000_0000;
        else if (ce)
            rdata_q <= reg_rd ? rd_word : 32'h0000_0000;
    end
    // ==========================================
    // outputs
    assign ext_addr = bus_q.addr;
    assign rd_n = bus_q.rd_n;
    assign wr_n = bus_q.wr_n;
    assign memory_select_n = bus_q.sel_n;
    assign channel_dma_grant_n = bus_q.grant_n;
    assign data_oe = bus_q.data_oe;
    assign data_out = dout_q;
    assign reg_rdata = rdata_q;
    wire unused_ok = strobing;
endmodule // edhp_port

// ==== edhp_port_assertions.sv ====
// assertions of the dma handshake port
`timescale 1ns/1ps
`include "edhp_params.svh"
module edhp_port_chk
(
    input wire logic core_clk, // clock
    input wire logic nrst, // async reset
    input wire logic [3:0] reg_addr, // register index
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic channel_dma_request_n, // request pin
    input wire logic rd_n, // read strobe
    input wire logic wr_n, // write strobe
    input wire logic [3:0] memory_select_n, // selects
    input wire logic channel_dma_grant_n, // grant pin
    input wire logic data_oe // data driven
);
    logic [31:0] ctrl_q;
    logic [7:0] low_q;
    wire ext_w = ctrl_q[2:1] == 2'h1;
    wire paced_w = ctrl_q[2:1] == 2'h2;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ==========
    // control copy and grant low count
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= 32'h0;
            low_q <= 8'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == `EDHP_REG_CTRL) ctrl_q <= reg_wdata;
            low_q <= channel_dma_grant_n ? 8'h0 : low_q + 8'h1;
        end
    end
    a_grant_after_reset: assert property (!$past(nrst) |-> channel_dma_grant_n) else $error("grant low at reset");
    a_grant_by_request: assert property ($fell(channel_dma_grant_n)
        |-> !$past(channel_dma_request_n) && !$past(channel_dma_request_n, 2)) else $error("grant without request");
    a_paced_no_grant: assert property (paced_w |-> channel_dma_grant_n) else $error("grant in paced mode");
    a_write_data_on: assert property ($fell(channel_dma_grant_n) && ctrl_q[3] |-> data_oe) else $error("data not driven");
    a_select_drive: assert property (ext_w && $fell(channel_dma_grant_n)
        |-> memory_select_n == ~ctrl_q[15:12]) else $error("select wrong");
    a_sync_release: assert property (ext_w && ctrl_q[4] && $rose(rd_n && wr_n)
        |-> $rose(channel_dma_grant_n)) else $error("sync strobe release");
    a_async_release: assert property (ext_w && !ctrl_q[4] && $rose(rd_n && wr_n)
        |=> $rose(channel_dma_grant_n)) else $error("strobe release");
    a_hold_by_request: assert property ($rose(channel_dma_grant_n) |-> $past(channel_dma_request_n))
        else $error("grant ended under request");
    a_wait_stretch: assert property ($rose(channel_dma_grant_n)
        |-> low_q >= 8'h1 + {4'h0, ctrl_q[11:8]}) else $error("grant too short");
endmodule // edhp_port_chk
bind edhp_port edhp_port_chk u_chk(.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .channel_dma_request_n(channel_dma_request_n), .rd_n(rd_n), .wr_n(wr_n),
    .memory_select_n(memory_select_n), .channel_dma_grant_n(channel_dma_grant_n), .data_oe(data_oe));

// ==== edhp_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module edhp_sync
(
    input wire logic core_clk, // clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic rst_val, // unused, both flops reset high
    input wire logic din, // pin input
    output logic dout // synchronised level
);
    logic meta_q;
    // two stages, first read only by second
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= 1'b1;
            dout <= 1'b1;
        end
        else if (ce)
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // edhp_sync

// ==== testbench.sv ====
// testbench of the dma handshake port
`timescale 1ns/1ps
`include "edhp_params.svh"
module testbench;
    logic core_clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    wire req_n, ack, grant_n, rd_n, wr_n, data_oe;
    wire [31:0] rdata, din, dout;
    wire [23:0] addr;
    wire [3:0] sel_n;
    int errors = 0, checks = 0, grants = 0, reads = 0;
    logic [31:0] base = 32'hc0de_0000;
    // clock and strobe counters
    always #5 core_clk = ~core_clk;
    always @(negedge grant_n) grants++;
    always @(negedge rd_n) reads++;
    edhp_port dut(.core_clk(core_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .channel_dma_request_n(req_n), .ack_in(ack),
        .data_in(din), .ext_addr(addr), .rd_n(rd_n), .wr_n(wr_n), .memory_select_n(sel_n),
        .channel_dma_grant_n(grant_n), .data_out(dout), .data_oe(data_oe));
    edhp_peer peer(.core_clk(core_clk), .grant_n(grant_n), .rd_n(rd_n), .wr_n(wr_n), .request_n(req_n),
        .ack(ack), .data(din));
    // ==========
    // shared tasks
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic complete_run();
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_write();
        logic [31:0] d;
        int g = grants;
        wr(`EDHP_REG_ADDR, 32'h10);
        wr(`EDHP_REG_WDATA, 32'h5a5a_0f0f);
        wr(`EDHP_REG_COUNT, 32'h2);
        wr(`EDHP_REG_CTRL, 32'h9);
        peer.run(2, 3);
        repeat (4) @(posedge core_clk);
        chk("grants", 32'(grants - g), 32'h2);
        chk("dout", dout, 32'h5a5a_0f0f);
        rd(`EDHP_REG_COUNT, d);
        chk("count", d, 32'h0);
        rd(`EDHP_REG_ADDR, d);
        chk("addr", d, 32'h12);
        base = base + 32'h2;
    endtask
    task automatic t_paced();
        logic [31:0] d;
        int g = grants;
        int r = reads;
        wr(`EDHP_REG_COUNT, 32'h1);
        wr(`EDHP_REG_CTRL, 32'h1205);
        peer.run(1, 0);
        repeat (4) @(posedge core_clk);
        chk("grants", 32'(grants - g), 32'h0);
        chk("reads", 32'(reads - r), 32'h1);
        rd(`EDHP_REG_DATA, d);
        chk("word", d, base);
        base = base + 32'h1;
    endtask
    task automatic t_fill();
        logic [31:0] d;
        int g = grants;
        wr(`EDHP_REG_COUNT, 32'h3);
        wr(`EDHP_REG_CTRL, 32'h2333);
        fork
            peer.run(3, 2);
            begin
                repeat (150) @(posedge core_clk);
                rd(`EDHP_REG_STAT, d);
                chk("room", {31'h0, d[5]}, 32'h0);
                chk("grants", 32'(grants - g), 32'h2);
                for (int i = 0; i < 2; i++)
                begin
                    rd(`EDHP_REG_DATA, d);
                    chk("word", d, base + 32'(i));
                end
            end
        join
        repeat (4) @(posedge core_clk);
        rd(`EDHP_REG_DATA, d);
        chk("word", d, base + 32'h2);
        base = base + 32'h3;
    endtask
    task automatic t_ext_write();
        logic [31:0] d;
        int g = grants;
        wr(`EDHP_REG_COUNT, 32'h1);
        wr(`EDHP_REG_CTRL, 32'h100b);
        peer.run(1, 1);
        repeat (4) @(posedge core_clk);
        chk("grants", 32'(grants - g), 32'h1);
        rd(4'hf, d);
        chk("unmapped", d, 32'h0);
    endtask
    // ==========
    // main sequence and watchdog
    initial
    begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        chk("grant", {31'h0, grant_n}, 32'h1);
        t_write();
        t_paced();
        t_fill();
        t_ext_write();
        complete_run();
    end
    initial
    begin
        #100000;
        errors++;
        complete_run();
    end
endmodule // testbench
